// *** hdl/tpw_pkg.sv ***
// package: register map, field layout and constants of the 8-bit pwm timer
package tpw_pkg;
	localparam int          ADDR_W       = 3;
	localparam int          DATA_W       = 8;
	localparam logic [2:0]  OFS_CTRL     = 3'h0;
	localparam logic [2:0]  OFS_COMPARE  = 3'h1;
	localparam logic [2:0]  OFS_COUNT    = 3'h2;
	localparam logic [2:0]  OFS_STATUS   = 3'h3;
	localparam logic [2:0]  OFS_PIN      = 3'h4;
	localparam logic [7:0]  CNT_MAX      = 8'hff;
	localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
	localparam logic [7:0]  RST_CTRL     = 8'h00;
	localparam logic [7:0]  RST_COMPARE  = 8'h00;
	localparam logic [7:0]  RST_COUNT    = 8'h00;
	localparam int          STS_OVF_BIT  = 0;
	localparam int          STS_OUT_BIT  = 1;
	localparam int          STS_DIR_BIT  = 2;
	localparam int          PIN_DIR_BIT  = 0;
	localparam int          PIN_DATA_BIT = 1;
	localparam int          PRE_W        = 10;
	localparam logic [9:0]  PRE_DIV1     = 10'h000;
	localparam logic [9:0]  PRE_DIV8     = 10'h007;
	localparam logic [9:0]  PRE_DIV64    = 10'h03f;
	localparam logic [9:0]  PRE_DIV256   = 10'h0ff;
	localparam logic [9:0]  PRE_DIV1024  = 10'h3ff;

	typedef enum logic [1:0] {
		WM_NORMAL = 2'b00,
		WM_PHASE  = 2'b01,
		WM_CTC    = 2'b10,
		WM_FAST   = 2'b11
	} tpw_wave_t;

	typedef enum logic [2:0] {
		CS_STOP    = 3'b000,
		CS_DIV1    = 3'b001,
		CS_DIV8    = 3'b010,
		CS_DIV64   = 3'b011,
		CS_DIV256  = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_EXT_F   = 3'b110,
		CS_EXT_R   = 3'b111
	} tpw_clksel_t;

	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} tpw_dir_t;

	// control register layout, bit 7 down to 0
	typedef struct packed {
		logic        unused;
		tpw_wave_t   waveform_mode;
		logic [1:0]  compare_output_mode;
		tpw_clksel_t clock_select;
	} tpw_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} tpw_bus_t;
endpackage

// *** hdl/tpw_top.sv ***
// top: 8-bit timer with fast and phase correct pwm waveform generation
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps

// What this block does
// - fast pwm sets overflow flag at max
// - fast pwm: mode two normal, three inverted
// - fast pwm: change at match, opposite at wrap
// - fast pwm period is 256 ticks
// - tick divides clock by 1,8,64,256,1024
// - fast pwm compare bottom gives one-tick spike
// - fast pwm compare max gives constant level
// - fast pwm mode one toggles on match
// - fast pwm compare value double buffered
// - waveform mode one counts up then down
// - phase mode: clear up-match, set down-match
// - phase correct resolution fixed eight bits
// - phase mode holds max one tick, reverses
// - phase mode sets overflow flag at bottom
// - phase correct period is 510 ticks
// - phase mode bottom low, max high
// - level at max equals up-match result unless compare is max
// - missed up-match still gives symmetry transition
// - pin driven only when direction is output
// - fully synchronous, tick is clock enable
// - waveform mode three selects fast pwm
// - max is 0xff, bottom is 0x00
// - compare at top ignored, top action kept
module tpw_top
	import tpw_pkg::*;
(
	input  wire logic                       SYS_CLK_I,
	input  wire logic                       NRST_I,
	input  wire logic [tpw_pkg::ADDR_W-1:0] ADDR_I,
	input  wire logic [tpw_pkg::DATA_W-1:0] WDATA_I,
	input  wire logic                       WR_I,
	input  wire logic                       RD_I,
	output logic      [tpw_pkg::DATA_W-1:0] RDATA_O,
	output logic                            OVERFLOW_FLAG_O,
	output logic                            COMPARE_OUTPUT_O,
	output logic                            COMPARE_OUTPUT_OE_O
);
	import tpw_pkg::*;

	tpw_bus_t          bus;
	tpw_ctrl_t         ctrl_q;
	logic [7:0]        compare_buf_q;
	logic [7:0]        compare_act_q;
	logic [7:0]        count_q;
	tpw_dir_t          dir_q;
	logic              ovf_q;
	logic              out_q;
	logic              pin_dir_q;
	logic              pin_data_q;
	logic              block_match_q;
	logic [PRE_W-1:0]  pre_q;
	logic [PRE_W-1:0]  pre_limit;
	logic              pre_run;
	logic              tick;
	logic              is_fast;
	logic              is_phase;
	logic              is_pwm;
	logic              at_max;
	logic              match;
	logic              ovf_set;
	logic              at_top;
	logic [7:0]        compare_next;
	logic              invert;
	logic              com_hi;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	assign is_fast  = (ctrl_q.waveform_mode == WM_FAST);
	assign is_phase = (ctrl_q.waveform_mode == WM_PHASE);
	assign is_pwm   = is_fast || is_phase;
	assign com_hi   = ctrl_q.compare_output_mode[1];
	assign invert   = ctrl_q.compare_output_mode[0];
	assign at_max   = (count_q == CNT_MAX);

	// prescaler: the tick only enables the timer logic, no derived clock
	always_comb begin
		pre_run   = 1'b1;
		pre_limit = PRE_DIV1;
		unique case (ctrl_q.clock_select)
			CS_DIV1:    pre_limit = PRE_DIV1;
			CS_DIV8:    pre_limit = PRE_DIV8;
			CS_DIV64:   pre_limit = PRE_DIV64;
			CS_DIV256:  pre_limit = PRE_DIV256;
			CS_DIV1024: pre_limit = PRE_DIV1024;
			// external clock source has no pin here, so it stops the timer
			CS_STOP, CS_EXT_F, CS_EXT_R: pre_run = 1'b0;
		endcase
	end

	assign tick = pre_run && (pre_q == pre_limit);

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pre_q <= '0;
		end else if (!pre_run || tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// top is the tick where the compare buffer is copied in
	assign at_top = tick && is_pwm && at_max && (is_fast || dir_q == DIR_UP);
	assign compare_next = compare_buf_q;

	// a counter write removes the match on the following tick
	assign match = tick && !block_match_q && (count_q == compare_act_q);

	always_comb begin
		ovf_set = 1'b0;
		if (tick) begin
			if (is_phase) begin
				ovf_set = (dir_q == DIR_DOWN) && (count_q == CNT_BOTTOM);
			end else begin
				ovf_set = at_max;
			end
		end
	end

	// control register
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_q <= tpw_ctrl_t'(RST_CTRL);
		end else if (bus.wr && bus.addr == OFS_CTRL) begin
			ctrl_q <= tpw_ctrl_t'({1'b0, bus.wdata[6:0]});
		end
	end

	// compare value: buffered in pwm modes, immediate otherwise
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			compare_buf_q <= RST_COMPARE;
		end else if (bus.wr && bus.addr == OFS_COMPARE) begin
			compare_buf_q <= bus.wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			compare_act_q <= RST_COMPARE;
		end else if (!is_pwm) begin
			compare_act_q <= compare_buf_q;
		end else if (at_top) begin
			compare_act_q <= compare_next;
		end
	end

	// counter and direction; resolution is the full eight bits in every pwm mode
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			count_q <= RST_COUNT;
			dir_q   <= DIR_UP;
		end else if (bus.wr && bus.addr == OFS_COUNT) begin
			count_q <= bus.wdata;
		end else if (tick) begin
			if (is_phase) begin
				if (dir_q == DIR_UP) begin
					if (at_max) begin
						count_q <= CNT_MAX - 8'h01;
						dir_q   <= DIR_DOWN;
					end else begin
						count_q <= count_q + 8'h01;
					end
				end else begin
					if (count_q == CNT_BOTTOM) begin
						count_q <= CNT_BOTTOM + 8'h01;
						dir_q   <= DIR_UP;
					end else begin
						count_q <= count_q - 8'h01;
					end
				end
			end else begin
				dir_q   <= DIR_UP;
				count_q <= at_max ? CNT_BOTTOM : count_q + 8'h01;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			block_match_q <= 1'b0;
		end else if (bus.wr && bus.addr == OFS_COUNT) begin
			block_match_q <= 1'b1;
		end else if (tick) begin
			block_match_q <= 1'b0;
		end
	end

	// overflow flag: write one to clear, a set in the same cycle wins
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ovf_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_q <= 1'b1;
		end else if (bus.wr && bus.addr == OFS_STATUS && bus.wdata[STS_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	// compare output state; mode bits act at once, not double buffered
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			out_q <= 1'b0;
		end else if (tick && is_fast) begin
			if (ctrl_q.compare_output_mode == 2'b01) begin
				if (match) begin
					out_q <= !out_q;
				end
			end else if (com_hi) begin
				if (at_max) begin
					out_q <= !invert;
				end else if (match) begin
					out_q <= invert;
				end
			end
		end else if (tick && is_phase && com_hi) begin
			if (at_top) begin
				// at max the level equals an up-match result unless compare is max, which also covers a missed up-match
				out_q <= (compare_next == CNT_MAX) ? !invert : invert;
			end else if (match && dir_q == DIR_UP) begin
				out_q <= invert;
			end else if (match && count_q != CNT_BOTTOM) begin
				// no down-match at bottom so a bottom compare stays constant
				out_q <= !invert;
			end
		end
	end

	// pin direction and plain port data
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pin_dir_q  <= 1'b0;
			pin_data_q <= 1'b0;
		end else if (bus.wr && bus.addr == OFS_PIN) begin
			pin_dir_q  <= bus.wdata[PIN_DIR_BIT];
			pin_data_q <= bus.wdata[PIN_DATA_BIT];
		end
	end

	// pin outputs registered; costs one clock of latency on the pin
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			COMPARE_OUTPUT_O    <= 1'b0;
			COMPARE_OUTPUT_OE_O <= 1'b0;
		end else begin
			COMPARE_OUTPUT_O    <= (ctrl_q.compare_output_mode != 2'b00) ? out_q : pin_data_q;
			COMPARE_OUTPUT_OE_O <= pin_dir_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			OVERFLOW_FLAG_O <= 1'b0;
		end else begin
			OVERFLOW_FLAG_O <= ovf_q;
		end
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			RDATA_O <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				OFS_CTRL:    RDATA_O <= ctrl_q;
				OFS_COMPARE: RDATA_O <= compare_buf_q;
				OFS_COUNT:   RDATA_O <= count_q;
				OFS_STATUS:  RDATA_O <= {5'h00, dir_q, out_q, ovf_q};
				OFS_PIN:     RDATA_O <= {6'h00, pin_data_q, pin_dir_q};
				default:     RDATA_O <= '0;
			endcase
		end else begin
			RDATA_O <= '0;
		end
	end
endmodule

// *** verification/tpw_top_sva.sv ***
// checker: port-level timing properties of the pwm timer
`timescale 1ns/10ps
module tpw_top_sva
	import tpw_pkg::*;
(
	input wire logic                       SYS_CLK_I,
	input wire logic                       NRST_I,
	input wire logic [tpw_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [tpw_pkg::DATA_W-1:0] WDATA_I,
	input wire logic                       WR_I,
	input wire logic                       RD_I,
	input wire logic [tpw_pkg::DATA_W-1:0] RDATA_O,
	input wire logic                       OVERFLOW_FLAG_O,
	input wire logic                       COMPARE_OUTPUT_O,
	input wire logic                       COMPARE_OUTPUT_OE_O
);
	logic [9:0] quiet_q;
	logic [7:0] cmp_q;
	tpw_ctrl_t  ctl_q;
	// wave shape judged only after a full period with no write, as loads wait for top
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			quiet_q <= 10'h000;
			cmp_q   <= 8'h00;
			ctl_q   <= tpw_ctrl_t'(8'h00);
		end else begin
			if (WR_I)
				quiet_q <= 10'h000;
			else if (quiet_q != 10'h3ff)
				quiet_q <= quiet_q + 10'h001;
			if (WR_I && ADDR_I == OFS_COMPARE)
				cmp_q <= WDATA_I;
			if (WR_I && ADDR_I == OFS_CTRL)
				ctl_q <= tpw_ctrl_t'(WDATA_I);
		end
	end
	wire logic ok_w    = quiet_q >= 10'h258 && ctl_q.clock_select == CS_DIV1 && ctl_q.compare_output_mode[1];
	wire logic fast_w  = ok_w && ctl_q.waveform_mode == WM_FAST;
	wire logic phase_w = ok_w && ctl_q.waveform_mode == WM_PHASE;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);
	AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data not zero outside answer");
	AST_OE_DIR: assert property ((WR_I && ADDR_I == OFS_PIN) ##1 !(WR_I && ADDR_I == OFS_PIN) |=>
		COMPARE_OUTPUT_OE_O == $past(WDATA_I[PIN_DIR_BIT], 2)) else $error("pin enable not per direction");
	AST_OVF_STICKY: assert property ($fell(OVERFLOW_FLAG_O) |->
		$past(WR_I && ADDR_I == OFS_STATUS && WDATA_I[STS_OVF_BIT], 2)) else $error("overflow flag lost");
	AST_FAST_MAX: assert property (fast_w && cmp_q == 8'hff |->
		COMPARE_OUTPUT_O == !ctl_q.compare_output_mode[0]) else $error("fast output not constant");
	AST_PHASE_EXT: assert property (phase_w && (cmp_q == 8'h00 || cmp_q == 8'hff) |->
		COMPARE_OUTPUT_O == ((cmp_q == 8'hff) ^ ctl_q.compare_output_mode[0])) else $error("phase extreme");
	AST_FAST_SPIKE: assert property (fast_w && cmp_q == 8'h00 && !ctl_q.compare_output_mode[0] &&
		$rose(COMPARE_OUTPUT_O) |=> !COMPARE_OUTPUT_O) else $error("spike not one tick");
	AST_FAST_PERIOD: assert property (fast_w && $rose(COMPARE_OUTPUT_O) |->
		##256 ($rose(COMPARE_OUTPUT_O) || quiet_q < 10'h100)) else $error("fast period wrong");
	AST_PHASE_PERIOD: assert property (phase_w && $rose(COMPARE_OUTPUT_O) |->
		##[510:510] ($rose(COMPARE_OUTPUT_O) || quiet_q < 10'h1fe)) else $error("phase period wrong");
	cover property (fast_w && $rose(COMPARE_OUTPUT_O));
	cover property (phase_w && $rose(COMPARE_OUTPUT_O));
	cover property ($fell(OVERFLOW_FLAG_O));
endmodule
bind tpw_top tpw_top_sva i_tpw_top_sva (.SYS_CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
	.OVERFLOW_FLAG_O, .COMPARE_OUTPUT_O, .COMPARE_OUTPUT_OE_O);

// *** verification/tpw_top_tb_top.sv ***
// testbench: register driver, read monitor and waveform measurements
`timescale 1ns/10ps
module tpw_top_tb_top;
	import tpw_pkg::*;
	logic       SYS_CLK_I;
	logic       NRST_I;
	logic [2:0] ADDR_I;
	logic [7:0] WDATA_I;
	logic       WR_I;
	logic       RD_I;
	logic [7:0] RDATA_O;
	logic       OVERFLOW_FLAG_O;
	logic       COMPARE_OUTPUT_O;
	logic       COMPARE_OUTPUT_OE_O;
	int         miscompares = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         seed;
	logic       rd_d = 1'b0;
	logic [7:0] exq[$];
	logic [7:0] modes[4] = '{8'h71, 8'h79, 8'h31, 8'h39};
	tpw_top i_tpw_top (.SYS_CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .OVERFLOW_FLAG_O,
		.COMPARE_OUTPUT_O, .COMPARE_OUTPUT_OE_O);
	initial begin
		SYS_CLK_I = 1'b0;
		forever #20 SYS_CLK_I = ~SYS_CLK_I;
	end
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge SYS_CLK_I);
		ADDR_I  <= a;
		WDATA_I <= d;
		WR_I    <= 1'b1;
		@(posedge SYS_CLK_I);
		WR_I    <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge SYS_CLK_I);
		ADDR_I <= a;
		RD_I   <= 1'b1;
		exq.push_back(e);
		@(posedge SYS_CLK_I);
		RD_I   <= 1'b0;
	endtask
	// read answers stand one cycle only, so the monitor samples every edge
	always @(posedge SYS_CLK_I) begin
		if (rd_d)
			chk("read data", {2'h0, exq.pop_front()}, {2'h0, RDATA_O});
		rd_d <= RD_I;
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic duty(input int w, input int e);
		int h;
		h = 0;
		repeat (w) begin
			@(posedge SYS_CLK_I);
			if (COMPARE_OUTPUT_O === 1'b1)
				h++;
		end
		chk("high ticks", e[9:0], h[9:0]);
	endtask
	task automatic clrovf;
		wr(OFS_STATUS, 8'h01);
		repeat (2) @(posedge SYS_CLK_I);
	endtask
	// spacing of two flag sets; both detections share one phase, so the gap is the period
	task automatic ovfgap(input logic [7:0] m, input int p);
		int n;
		wr(OFS_CTRL, m);
		for (int i = 0; i < 2; i++) begin
			clrovf();
			n = 0;
			while (OVERFLOW_FLAG_O !== 1'b1 && n < 2000) begin
				@(posedge SYS_CLK_I);
				n++;
			end
		end
		chk("overflow spacing", p[9:0], 10'(n + 4));
	endtask
	initial begin
		int c;
		seed = 35397;
		NRST_I = 1'b0;
		ADDR_I = 3'h0;
		WDATA_I = 8'h00;
		WR_I = 1'b0;
		RD_I = 1'b0;
		repeat (16) @(posedge SYS_CLK_I);
		NRST_I <= 1'b1;
		for (int a = 0; a < 6; a++)
			rd(a[2:0], 8'h00);
		wr(OFS_PIN, 8'h03);
		repeat (3) @(posedge SYS_CLK_I);
		chk("pin out", 10'h3, {8'h0, COMPARE_OUTPUT_OE_O, COMPARE_OUTPUT_O});
		wr(OFS_CTRL, 8'h70);
		wr(OFS_COUNT, 8'ha5);
		wr(OFS_COMPARE, 8'h5a);
		rd(OFS_COUNT, 8'ha5);
		rd(OFS_COMPARE, 8'h5a);
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 3; k++) begin
				c = (k == 0) ? 0 : (k == 1) ? 255 : ($random(seed) & 255);
				wr(OFS_COMPARE, c[7:0]);
				wr(OFS_CTRL, modes[m]);
				repeat (600) @(posedge SYS_CLK_I);
				if (m < 2)
					duty(256, m[0] ? 255 - c : c + 1);
				else
					duty(510, m[0] ? 510 - 2 * c : 2 * c);
			end
		wr(OFS_COMPARE, 8'h00);
		wr(OFS_CTRL, 8'h69);
		repeat (600) @(posedge SYS_CLK_I);
		duty(512, 256);
		ovfgap(8'h71, 256);
		ovfgap(8'h31, 510);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_COUNT, 8'h00);
		// start from a stopped prescaler so the tick phase is known: one tick every eighth clock
		wr(OFS_CTRL, 8'h02);
		repeat (79) @(posedge SYS_CLK_I);
		rd(OFS_COUNT, 8'h0a);
		wr(OFS_PIN, 8'h02);
		repeat (3) @(posedge SYS_CLK_I);
		chk("pin out", 10'h1, {8'h0, COMPARE_OUTPUT_OE_O, COMPARE_OUTPUT_O});
		print_verdict();
	end
endmodule
